// File: rtl/vmf_fault.sv
// virtual memory fault detector and status for page fault and limit errors
// assumes access strobes are one-cycle pulses on clk_sys from on-chip requesters
// Overview of operation
// - write fault by other requester sets bit 11
// - cache or reassembly write fault sets bit 10
// - cache DMA failure marks frame header field
// - scheduler blocks marked frame from segmentation under free or event policy
// - scheduler policy: send, free, or event
// - reassembly write fault drops current packet
// - read page fault sets bit 9
// - unlocked read fault maps page, returns data
// - predictive fill crossing segment sets bit 9
// - partial uncached write readback near start sets 9
// - access over buffer limit sets bit 8
// - lock enable set halts failing operation
`include "vmf_defs.svh"
module vmf_fault #(
    parameter int AW = 32
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // access side
    input  wire logic              acc_valid,
    input  wire logic              acc_write,
    input  wire vmf_pkg::vmf_req_e acc_req,
    input  wire logic [AW-1:0]     acc_addr,
    input  wire logic [AW-1:0]     acc_seg_off,
    input  wire logic              acc_page_miss,
    input  wire logic              acc_prefetch,
    input  wire logic              acc_partial_hit,
    input  wire logic [AW-1:0]     buf_max_size,
    output logic                   acc_halt,
    output logic                   acc_map_page,
    output logic                   acc_done,
    output logic                   hdr_mark,
    output logic                   rx_drop,
    // status and lock enables
    input  wire logic [3:0]        lock_en,
    input  wire logic [3:0]        stat_clr,
    output logic [3:0]             stat,
    // transmit scheduler
    input  wire logic              enq_valid,
    input  wire logic [7:0]        enq_hdr,
    input  wire logic [15:0]       enq_buf,
    input  wire vmf_pkg::vmf_pol_e sched_policy,
    output logic                   seg_valid,
    output logic [15:0]            seg_buf,
    output logic                   free_valid,
    output logic [15:0]            free_buf,
    output logic                   sched_event
);
    // -----------------------------------------------------------------
    // detection
    // -----------------------------------------------------------------
    typedef struct packed {
        logic halt;
        logic map_page;
        logic done;
        logic hdr_mark;
        logic rx_drop;
    } vmf_fault_s;
    vmf_fault_s st;
    vmf_fault_s next_st;
    logic [3:0] ev;
    logic       recov_req;
    logic       wr_fault;
    logic       rd_fault;
    logic       over;
    logic       near_start;
    always_comb begin
        recov_req  = (acc_req == vmf_pkg::VMF_REQ_CACHE) ||
                     (acc_req == vmf_pkg::VMF_REQ_REASM);
        wr_fault   = acc_valid && acc_write && acc_page_miss;
        near_start = acc_seg_off < `VMF_SEG_NEAR;
        // prefetch crossing a segment reports a miss; harmless but flagged
        rd_fault   = acc_valid && !acc_write &&
                     (acc_page_miss || acc_prefetch ||
                      (acc_partial_hit && near_start));
        over       = acc_valid && (acc_addr > buf_max_size);
        ev = '0;
        ev[`VMF_BIT_WR_FATAL - `VMF_BIT_LIMIT] = wr_fault && !recov_req;
        ev[`VMF_BIT_WR_RECOV - `VMF_BIT_LIMIT] = wr_fault && recov_req;
        ev[`VMF_BIT_RD_FAULT - `VMF_BIT_LIMIT] = rd_fault;
        ev[0]                                  = over;
        next_st = '0;
        // halt only when a lock enable matches; read enables may be off
        next_st.halt = |(ev & lock_en);
        next_st.done = acc_valid && !next_st.halt;
        next_st.map_page = rd_fault && !lock_en[1];
        next_st.hdr_mark = wr_fault && acc_req == vmf_pkg::VMF_REQ_CACHE;
        next_st.rx_drop  = wr_fault && acc_req == vmf_pkg::VMF_REQ_REASM;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign acc_halt     = st.halt;
    assign acc_map_page = st.map_page;
    assign acc_done     = st.done;
    assign hdr_mark     = st.hdr_mark;
    assign rx_drop      = st.rx_drop;
    // -----------------------------------------------------------------
    // status and scheduler
    // -----------------------------------------------------------------
    vmf_sticky #(.W(`VMF_STAT_W)) u_stat (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     (ev),
        .clr     (stat_clr),
        .stat    (stat)
    );
    vmf_sched_chk u_sched (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .enq_valid   (enq_valid),
        .enq_hdr     (enq_hdr),
        .enq_buf     (enq_buf),
        .policy      (sched_policy),
        .seg_valid   (seg_valid),
        .seg_buf     (seg_buf),
        .free_valid  (free_valid),
        .free_buf    (free_buf),
        .event_pulse (sched_event)
    );
    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_fatal_wr_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_OTHER)
        |=> stat[3])
        else $error("fatal write fault not flagged");

    a_recov_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_OTHER &&
         !stat[2]) |=> !stat[2])
        else $error("fatal write fault set the recoverable bit");

    a_recov_wr_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && (acc_req == vmf_pkg::VMF_REQ_CACHE ||
         acc_req == vmf_pkg::VMF_REQ_REASM)) |=> stat[2])
        else $error("recoverable write fault not flagged");

    a_fatal_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && !stat[3] &&
         (acc_req == vmf_pkg::VMF_REQ_CACHE || acc_req == vmf_pkg::VMF_REQ_REASM)) |=> !stat[3])
        else $error("recoverable write fault set the fatal bit");

    a_hdr_mark : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_CACHE)
        |=> hdr_mark)
        else $error("header not marked");

    a_hdr_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_CACHE)
        |=> !hdr_mark)
        else $error("header marked without a cache write fault");

    a_rx_drop : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_REASM)
        |=> rx_drop)
        else $error("packet not dropped");

    a_drop_only : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_REASM)
        |=> !rx_drop)
        else $error("packet dropped without a reassembly write fault");

    a_rd_fault : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && (acc_page_miss || acc_prefetch))
        |=> stat[1])
        else $error("read fault not flagged");

    a_wr_no_rd : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && !stat[1])
        |=> !stat[1])
        else $error("write set the read fault bit");

    a_map_unlock : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && acc_page_miss && !lock_en[1])
        |=> acc_map_page)
        else $error("page not mapped on unlocked read fault");

    a_no_map_lock : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!acc_valid || acc_write || lock_en[1])
        |=> !acc_map_page)
        else $error("page mapped while locked or without a read");

    a_prefetch_rd : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && acc_prefetch)
        |=> stat[1])
        else $error("crossing prefetch not flagged");

    a_partial_rd : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && acc_partial_hit && acc_seg_off < `VMF_SEG_NEAR)
        |=> stat[1])
        else $error("partial readback not flagged");

    a_far_partial : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && !acc_page_miss && !acc_prefetch && !stat[1] &&
         acc_seg_off >= `VMF_SEG_NEAR) |=> !stat[1])
        else $error("read fault flagged far from segment start");

    a_limit_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_addr > buf_max_size)
        |=> stat[0])
        else $error("limit error not flagged");

    a_limit_edge : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_addr <= buf_max_size && !stat[0])
        |=> !stat[0])
        else $error("limit error flagged inside the limit");

    a_lock_halt : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_addr > buf_max_size && lock_en[0])
        |=> (acc_halt && !acc_done))
        else $error("locked failure did not halt");

    a_fatal_halt : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && acc_write && acc_page_miss && acc_req == vmf_pkg::VMF_REQ_OTHER &&
         lock_en[3]) |=> (acc_halt && !acc_done))
        else $error("locked write fault did not halt");

    a_rd_halt : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_write && acc_page_miss && lock_en[1])
        |=> (acc_halt && !acc_done && !acc_map_page))
        else $error("locked read fault did not halt");

    a_done_free : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_valid && !acc_page_miss && !acc_prefetch && !acc_partial_hit &&
         acc_addr <= buf_max_size) |=> (acc_done && !acc_halt))
        else $error("clean access did not complete");

    a_idle_quiet : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !acc_valid
        |=> !(acc_halt || acc_map_page || acc_done || hdr_mark || rx_drop))
        else $error("access answer without an access");

    a_halt_or_done : assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot0({acc_halt, acc_done}))
        else $error("access both halted and completed");

    a_reset_clear : assert property (@(posedge clk_sys)
        !rst_n
        |=> stat == `VMF_STAT_RESET)
        else $error("status not cleared by reset");

    a_sched_send : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enq_valid && (!enq_hdr[`VMF_HDR_FAIL_BIT] || sched_policy == vmf_pkg::VMF_POL_SEND))
        |=> (seg_valid && seg_buf == $past(enq_buf)))
        else $error("frame not passed to segmentation");

    a_sched_free : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enq_valid && enq_hdr[`VMF_HDR_FAIL_BIT] && sched_policy == vmf_pkg::VMF_POL_FREE)
        |=> (free_valid && !seg_valid && free_buf == $past(enq_buf)))
        else $error("marked frame not freed");

    a_sched_event : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enq_valid && enq_hdr[`VMF_HDR_FAIL_BIT] && sched_policy == vmf_pkg::VMF_POL_EVENT)
        |=> (sched_event && !seg_valid))
        else $error("marked frame raised no event");

    a_sched_quiet : assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enq_valid
        |=> !(seg_valid || free_valid || sched_event))
        else $error("scheduler output without an enqueue");

    a_sched_onehot : assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot0({seg_valid, free_valid, sched_event}))
        else $error("frame handed to more than one place");

    // -----------------------------------------------------------------
    // per-bit status and lock checks
    // -----------------------------------------------------------------
    generate
        for (genvar gi = 0; gi < `VMF_STAT_W; gi++) begin : g_bit
            a_bit_set : assert property (@(posedge clk_sys) disable iff (!rst_n)
                ev[gi]
                |=> stat[gi])
                else $error("event did not set its status bit");

            a_bit_halt : assert property (@(posedge clk_sys) disable iff (!rst_n)
                (ev[gi] && lock_en[gi])
                |=> (acc_halt && !acc_done))
                else $error("locked event did not halt");

            a_bit_clear : assert property (@(posedge clk_sys) disable iff (!rst_n)
                (stat_clr[gi] && !ev[gi])
                |=> !stat[gi])
                else $error("status bit not cleared");

            a_bit_keep : assert property (@(posedge clk_sys) disable iff (!rst_n)
                (stat[gi] && !stat_clr[gi])
                |=> stat[gi])
                else $error("status bit dropped without clear");
        end
    endgenerate

    c_wr_fatal : cover property (@(posedge clk_sys) disable iff (!rst_n) stat[3]);
    c_rd_map   : cover property (@(posedge clk_sys) disable iff (!rst_n) acc_map_page);
    c_halt     : cover property (@(posedge clk_sys) disable iff (!rst_n) acc_halt);
    c_benign   : cover property (@(posedge clk_sys) disable iff (!rst_n)
        acc_valid && !acc_write && acc_prefetch && !lock_en[1]);
endmodule

// File: rtl/vmf_defs.svh
// constants for the virtual memory fault status block
// assumes inclusion by every design module of the block
`ifndef VMF_DEFS_SVH
`define VMF_DEFS_SVH
`define VMF_BIT_LIMIT      8
`define VMF_BIT_RD_FAULT   9
`define VMF_BIT_WR_RECOV   10
`define VMF_BIT_WR_FATAL   11
`define VMF_STAT_W         4
`define VMF_STAT_RESET     4'h0
`define VMF_SEG_NEAR       32'h0000_0020
`define VMF_HDR_FAIL_BIT   0
`endif

// File: rtl/vmf_pkg.sv
// types for the virtual memory fault status block
// assumes vmf_defs.svh is compiled alongside
package vmf_pkg;
    typedef enum logic [1:0] {
        VMF_POL_SEND  = 2'b00,
        VMF_POL_FREE  = 2'b01,
        VMF_POL_EVENT = 2'b10
    } vmf_pol_e;
    typedef enum logic [1:0] {
        VMF_REQ_OTHER = 2'b00,
        VMF_REQ_CACHE = 2'b01,
        VMF_REQ_REASM = 2'b10
    } vmf_req_e;
endpackage

// File: rtl/vmf_sticky.sv
// one sticky status bit per event, cleared by write-one
// assumes set and clear come from logic on clk_sys
`include "vmf_defs.svh"
module vmf_sticky #(
    parameter int W = `VMF_STAT_W
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] stat
);
    typedef struct packed {
        logic [W-1:0] bits;
    } vmf_sticky_s;
    vmf_sticky_s st;
    vmf_sticky_s next_st;
    always_comb begin
        next_st = st;
        for (int i = 0; i < W; i++) begin
            // set beats clear so no event is lost
            if (set[i]) begin
                next_st.bits[i] = 1'b1;
            end else if (clr[i]) begin
                next_st.bits[i] = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st.bits <= W'(`VMF_STAT_RESET);
        end else begin
            st <= next_st;
        end
    end
    assign stat = st.bits;
    a_sticky_hold : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.bits != '0 && clr == '0) |=> ((st.bits & $past(st.bits)) == $past(st.bits)))
        else $error("sticky bit lost without clear");
endmodule

// File: rtl/vmf_sched_chk.sv
// transmit scheduler check of a frame header fail mark
// assumes one enqueue pulse with header on clk_sys
`include "vmf_defs.svh"
module vmf_sched_chk (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              enq_valid,
    input  wire logic [7:0]        enq_hdr,
    input  wire logic [15:0]       enq_buf,
    input  wire vmf_pkg::vmf_pol_e policy,
    output logic                   seg_valid,
    output logic [15:0]            seg_buf,
    output logic                   free_valid,
    output logic [15:0]            free_buf,
    output logic                   event_pulse
);
    typedef struct packed {
        logic        seg_valid;
        logic        free_valid;
        logic        event_pulse;
        logic [15:0] buf_id;
    } vmf_sched_s;
    vmf_sched_s st;
    vmf_sched_s next_st;
    logic       bad;
    always_comb begin
        bad = enq_hdr[`VMF_HDR_FAIL_BIT];
        next_st = '0;
        next_st.buf_id = enq_buf;
        if (enq_valid) begin
            if (!bad || policy == vmf_pkg::VMF_POL_SEND) begin
                next_st.seg_valid = 1'b1;
            end else if (policy == vmf_pkg::VMF_POL_FREE) begin
                next_st.free_valid = 1'b1;
            end else begin
                next_st.event_pulse = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign seg_valid   = st.seg_valid;
    assign seg_buf     = st.buf_id;
    assign free_valid  = st.free_valid;
    assign free_buf    = st.buf_id;
    assign event_pulse = st.event_pulse;
    a_bad_no_seg : assert property (@(posedge clk_sys) disable iff (!rst_n)
        (enq_valid && enq_hdr[0] && policy != vmf_pkg::VMF_POL_SEND) |=> !seg_valid)
        else $error("failed frame passed to segmentation");
    c_sched_free : cover property (@(posedge clk_sys) free_valid);
endmodule

// File: bench/vmf_mem_model.sv
// memory controller model: reports page faults for a no-buffer region
// assumes combinational answer to the access presented on the same cycle
module vmf_mem_model #(
    parameter logic [31:0] MISS_LO = 32'h0000_0080,
    parameter logic [31:0] MISS_HI = 32'h0000_00ff
) (
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    output logic             page_miss
);
    timeunit 1ns;
    timeprecision 1ps;
    // low outside strobes so a stuck miss cannot hide a missing fault
    assign page_miss = acc_valid && acc_addr >= MISS_LO && acc_addr <= MISS_HI;
endmodule

// File: bench/test_virtual_memory_fault_status.sv
// self-checking bench of the virtual memory fault status block
// assumes vmf_pkg and the design files are compiled before this file
module test_virtual_memory_fault_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
    logic acc_prefetch = 1'b0, acc_partial_hit = 1'b0, enq_valid = 1'b0, miss;
    vmf_pkg::vmf_req_e acc_req = vmf_pkg::VMF_REQ_OTHER;
    vmf_pkg::vmf_pol_e pol = vmf_pkg::VMF_POL_SEND;
    logic [31:0] acc_addr = 32'h0, acc_seg_off = 32'h0;
    logic [3:0]  lock_en = 4'h0, stat_clr = 4'h0, stat;
    logic [7:0]  enq_hdr = 8'h0;
    logic [15:0] enq_buf = 16'h0, seg_buf, free_buf;
    logic        halt, mapp, done, hdr_mark, rx_drop, seg_v, free_v, ev;
    int          fail_count = 0, n_checks = 0, cyc = 0;
    vmf_mem_model u_mem (.acc_valid(acc_valid), .acc_addr(acc_addr), .page_miss(miss));
    vmf_fault u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_req(acc_req), .acc_addr(acc_addr),
        .acc_seg_off(acc_seg_off), .acc_page_miss(miss), .acc_prefetch(acc_prefetch),
        .acc_partial_hit(acc_partial_hit), .buf_max_size(32'h0000_0100), .acc_halt(halt),
        .acc_map_page(mapp), .acc_done(done), .hdr_mark(hdr_mark), .rx_drop(rx_drop),
        .lock_en(lock_en), .stat_clr(stat_clr), .stat(stat), .enq_valid(enq_valid),
        .enq_hdr(enq_hdr), .enq_buf(enq_buf), .sched_policy(pol), .seg_valid(seg_v),
        .seg_buf(seg_buf), .free_valid(free_v), .free_buf(free_buf), .sched_event(ev));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one access; compares {halt,map,done,hdr,drop,stat} in the answer cycle
    task automatic acc(input logic w, input vmf_pkg::vmf_req_e r, input logic [31:0] a,
                       input logic [31:0] off, input logic pf, input logic ph,
                       input logic [8:0] exp);
        acc_valid = 1'b1;
        acc_write = w;
        acc_req = r;
        acc_addr = a;
        acc_seg_off = off;
        acc_prefetch = pf;
        acc_partial_hit = ph;
        @(negedge clk_sys);
        acc_valid = 1'b0;
        acc_prefetch = 1'b0;
        acc_partial_hit = 1'b0;
        chk({11'h0, halt, mapp, done, hdr_mark, rx_drop, stat}, {11'h0, exp});
        // idle edge so a next call never re-raises the strobe in the same step
        @(negedge clk_sys);
    endtask
    task automatic clear_all();
        stat_clr = 4'hf;
        @(negedge clk_sys);
        stat_clr = 4'h0;
        chk({16'h0, stat}, 20'h0);
    endtask
    // one enqueue; compares {seg,free,event} and the handed-on buffer
    task automatic enq(input logic [7:0] h, input vmf_pkg::vmf_pol_e p, input logic [2:0] exp);
        enq_valid = 1'b1;
        enq_hdr = h;
        enq_buf = {8'ha5, h};
        pol = p;
        @(negedge clk_sys);
        enq_valid = 1'b0;
        chk({1'b0, seg_v, free_v, ev, exp[2] ? seg_buf : exp[1] ? free_buf : 16'h0},
            {1'b0, exp, (exp[2] | exp[1]) ? {8'ha5, h} : 16'h0});
        @(negedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        chk({16'h0, stat}, 20'h0);
        // -------------------------------------------------------------------
        // write faults by requester
        // -------------------------------------------------------------------
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h90, 32'h40, 0, 0, 9'b001001000);
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h10, 32'h40, 0, 0, 9'b001001000);
        clear_all();
        acc(1, vmf_pkg::VMF_REQ_CACHE, 32'h90, 32'h40, 0, 0, 9'b001100100);
        clear_all();
        acc(1, vmf_pkg::VMF_REQ_REASM, 32'h90, 32'h40, 0, 0, 9'b001010100);
        clear_all();
        // event and clear in one cycle: the event wins
        stat_clr = 4'h8;
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h90, 32'h40, 0, 0, 9'b001001000);
        clear_all();
        // -------------------------------------------------------------------
        // read faults, benign ones included
        // -------------------------------------------------------------------
        lock_en = 4'h0;
        acc(0, vmf_pkg::VMF_REQ_REASM, 32'h90, 32'h40, 0, 0, 9'b011000010);
        clear_all();
        acc(0, vmf_pkg::VMF_REQ_OTHER, 32'h10, 32'h40, 1, 0, 9'b011000010);
        clear_all();
        acc(0, vmf_pkg::VMF_REQ_CACHE, 32'h10, 32'h1f, 0, 1, 9'b011000010);
        clear_all();
        acc(0, vmf_pkg::VMF_REQ_CACHE, 32'h10, 32'h20, 0, 1, 9'b001000000);
        // -------------------------------------------------------------------
        // limit boundary and lock halts
        // -------------------------------------------------------------------
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h100, 32'h0, 0, 0, 9'b001000000);
        acc(0, vmf_pkg::VMF_REQ_OTHER, 32'h101, 32'h0, 0, 0, 9'b001000001);
        clear_all();
        lock_en = 4'hf;
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h90, 32'h40, 0, 0, 9'b100001000);
        acc(0, vmf_pkg::VMF_REQ_OTHER, 32'h90, 32'h40, 0, 0, 9'b100001010);
        clear_all();
        // mid-run reset must drop a standing status bit
        lock_en = 4'h0;
        acc(1, vmf_pkg::VMF_REQ_OTHER, 32'h90, 32'h40, 0, 0, 9'b001001000);
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        chk({16'h0, stat}, 20'h0);
        // -------------------------------------------------------------------
        // scheduler handling of marked and clean frames
        // -------------------------------------------------------------------
        enq(8'h00, vmf_pkg::VMF_POL_EVENT, 3'b100);
        enq(8'h01, vmf_pkg::VMF_POL_SEND, 3'b100);
        enq(8'h03, vmf_pkg::VMF_POL_FREE, 3'b010);
        enq(8'h05, vmf_pkg::VMF_POL_EVENT, 3'b001);
        print_verdict();
    end
endmodule
